// ---- rsd_alu.sv ----
// Notes on behaviour
// - literal loop repeats next instruction count+1 times
// - register loop repeats count+1 times, no flags
// - return loads 10-bit literal, three or two cycles
// - rotate left carry: carry in, msb out
// - rotate left plain: msb to bit0, carry kept
// - rotate right carry: carry in, bit0 out
// - rotate right plain: bit0 to msb, one cycle
// - sign extend low byte, updates carry, negative, zero
// - shift left by register amount, only negative, zero
// - shift left by 5-bit literal, one cycle
// - subtract with borrow uses inverted carry
// - reverse subtract borrow: source register minus base register
// - table read high byte into low byte, two cycles
package rsd_pkg;
    localparam int NUM_W    = 16;
    localparam int NUM_PROG = 8;

    localparam logic [11:0] ADDR_INSTR     = 12'h000;
    localparam logic [11:0] ADDR_STATUS    = 12'h004;
    localparam logic [11:0] ADDR_FREG      = 12'h008;
    localparam logic [11:0] ADDR_REPCNT    = 12'h00C;
    localparam logic [11:0] ADDR_WORK_BASE = 12'h040;
    localparam logic [11:0] ADDR_PROG_BASE = 12'h080;

    localparam int OP_LSB   = 0;
    localparam int MODE_LSB = 5;
    localparam int FAST_BIT = 7;
    localparam int WD_LSB   = 8;
    localparam int WB_LSB   = 12;
    localparam int WS_LSB   = 16;
    localparam int LIT_LSB  = 18;

    localparam logic [1:0] MODE_FILE = 2'h1;
    localparam logic [1:0] MODE_ACC  = 2'h2;

    localparam int FLG_C     = 0;
    localparam int FLG_DIGIT = 1;
    localparam int FLG_N     = 2;
    localparam int FLG_RANGE = 3;
    localparam int FLG_Z     = 4;
    localparam logic [4:0] UPD_CNZ = 5'h15;
    localparam logic [4:0] UPD_NZ  = 5'h14;
    localparam logic [4:0] UPD_ALL = 5'h1F;

    localparam logic [4:0]  FLAGS_RST = 5'h00;
    localparam logic [15:0] WORD_RST  = 16'h0000;
    localparam logic [23:0] PROG_RST  = 24'h000000;
    localparam logic [31:0] INSTR_RST = 32'h00000000;
    localparam logic [15:0] ALL_ONES  = 16'hFFFF;

    localparam logic [1:0] CYC_RET_SLOW = 2'h3;
    localparam logic [1:0] CYC_RET_FAST = 2'h2;
    localparam logic [1:0] CYC_TBL      = 2'h2;

    typedef enum logic [4:0] {
        OP_NOP, OP_ROT_LEFT_CARRY, OP_ROT_LEFT_PLAIN, OP_ROT_RIGHT_CARRY, OP_ROT_RIGHT_PLAIN,
        OP_SIGN_EXTEND, OP_SET_ALL_ONES, OP_SHIFT_LEFT_REG, OP_SHIFT_LEFT_LIT,
        OP_SUBTRACT, OP_SUBTRACT_BORROW, OP_REV_SUBTRACT, OP_REV_SUBTRACT_BORROW,
        OP_SUBTRACT_LIT, OP_SUBTRACT_BORROW_LIT, OP_REV_SUBTRACT_LIT, OP_REV_SUBTRACT_BORROW_LIT,
        OP_LOOP_LIT, OP_LOOP_REG, OP_RETURN_WITH_LITERAL, OP_TABLE_READ_HIGH
    } rsd_op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_WAIT = 2'b11
    } rsd_state_e;
endpackage

`timescale 1ns/1ns
module rsd_alu
    import rsd_pkg::*;
(
    input  wire rsd_op_e    op,
    input  wire logic [15:0] a,
    input  wire logic [15:0] b,
    input  wire logic [4:0]  amt,
    input  wire logic        cin,
    input  wire logic [9:0]  lit10,
    input  wire logic [7:0]  prog_hi,
    output logic      [15:0] res,
    output logic      [4:0]  flg,
    output logic      [4:0]  upd,
    output logic             wr
);
    logic        rev;
    logic        use_c;
    logic        ci;
    logic [15:0] x;
    logic [15:0] y;
    logic [16:0] sum;
    logic [4:0]  lo;

    always_comb
    begin
        rev   = op inside {OP_REV_SUBTRACT, OP_REV_SUBTRACT_BORROW, OP_REV_SUBTRACT_LIT,
                           OP_REV_SUBTRACT_BORROW_LIT};
        use_c = op inside {OP_SUBTRACT_BORROW, OP_REV_SUBTRACT_BORROW, OP_SUBTRACT_BORROW_LIT,
                           OP_REV_SUBTRACT_BORROW_LIT};
        // borrow forms feed the carry as the +1 of two's complement, so c=0 subtracts one more
        ci    = use_c ? cin : 1'b1;
        x     = rev ? b : a;
        y     = rev ? a : b;
        sum   = {1'b0, x} + {1'b0, ~y} + {16'h0000, ci};
        lo    = {1'b0, x[3:0]} + {1'b0, ~y[3:0]} + {4'h0, ci};
        res   = sum[15:0];
        flg   = 5'h00;
        upd   = UPD_ALL;
        wr    = 1'b1;
        case (op)
            OP_ROT_LEFT_CARRY:
            begin
                res        = {a[14:0], cin};
                flg[FLG_C] = a[15];
                upd        = UPD_CNZ;
            end
            OP_ROT_LEFT_PLAIN:
            begin
                res = {a[14:0], a[15]};
                upd = UPD_NZ;
            end
            OP_ROT_RIGHT_CARRY:
            begin
                res        = {cin, a[15:1]};
                flg[FLG_C] = a[0];
                upd        = UPD_CNZ;
            end
            OP_ROT_RIGHT_PLAIN:
            begin
                res = {a[0], a[15:1]};
                upd = UPD_NZ;
            end
            OP_SIGN_EXTEND:
            begin
                res        = {{8{a[7]}}, a[7:0]};
                flg[FLG_C] = ~a[7];
                upd        = UPD_CNZ;
            end
            OP_SET_ALL_ONES:
            begin
                res = ALL_ONES;
                upd = 5'h00;
            end
            OP_SHIFT_LEFT_REG, OP_SHIFT_LEFT_LIT:
            begin
                // amounts of 16 and above shift everything out
                res = amt[4] ? WORD_RST : (a << amt[3:0]);
                upd = UPD_NZ;
            end
            OP_RETURN_WITH_LITERAL:
            begin
                res = {6'h00, lit10};
                upd = 5'h00;
            end
            OP_TABLE_READ_HIGH:
            begin
                res = {8'h00, prog_hi};
                upd = 5'h00;
            end
            OP_NOP, OP_LOOP_LIT, OP_LOOP_REG:
            begin
                wr  = 1'b0;
                upd = 5'h00;
            end
            default:
            begin
                flg[FLG_C]  = sum[16];
                flg[FLG_DIGIT] = lo[4];
                flg[FLG_RANGE] = (x[15] ^ y[15]) & (x[15] ^ sum[15]);
            end
        endcase
        flg[FLG_N] = res[15];
        flg[FLG_Z] = (res == WORD_RST);
    end
endmodule

// ---- rsd_datapath.sv ----
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ns
module rsd_datapath
    import rsd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             return_pulse
);
    logic [15:0] w_ff     [NUM_W];
    logic [15:0] nxt_w    [NUM_W];
    logic [23:0] prog_ff  [NUM_PROG];
    logic [23:0] nxt_prog [NUM_PROG];
    logic [15:0] freg_ff;
    logic [15:0] nxt_freg;
    logic [4:0]  flags_ff;
    logic [4:0]  nxt_flags;
    logic [31:0] instr_ff;
    logic [31:0] nxt_instr;
    rsd_state_e  state_ff;
    rsd_state_e  nxt_state;
    logic [1:0]  wait_ff;
    logic [1:0]  nxt_wait;
    logic [13:0] rep_ff;
    logic [13:0] nxt_rep;
    logic        armed_ff;
    logic        nxt_armed;
    logic        ret_ff;
    logic        nxt_ret;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;

    rsd_op_e     op;
    logic [1:0]  mode;
    logic [3:0]  wd;
    logic [3:0]  wb;
    logic [3:0]  ws;
    logic [13:0] lit14;
    logic        fast;
    logic        busy;
    logic        access;
    logic        addr_ok;
    logic        is_w;
    logic        is_p;
    logic        wr_take;
    logic        file_src;
    logic        lit_src;
    logic        unary;
    logic [15:0] src_a;
    logic [15:0] src_b;
    logic [4:0]  amt;
    logic [15:0] alu_res;
    logic [4:0]  alu_flg;
    logic [4:0]  alu_upd;
    logic        alu_wr;
    logic [1:0]  extra;
    logic        fin;
    logic [31:0] rd_word;

    assign op    = rsd_op_e'(instr_ff[OP_LSB +: 5]);
    assign mode  = instr_ff[MODE_LSB +: 2];
    assign fast  = instr_ff[FAST_BIT];
    assign wd    = instr_ff[WD_LSB +: 4];
    assign wb    = instr_ff[WB_LSB +: 4];
    assign ws    = instr_ff[WS_LSB +: 4];
    assign lit14 = instr_ff[LIT_LSB +: 14];

    assign busy    = (state_ff != ST_IDLE);
    assign access  = psel & penable;
    assign is_w    = (paddr[11:6] == ADDR_WORK_BASE[11:6]);
    assign is_p    = (paddr[11:5] == ADDR_PROG_BASE[11:5]);
    assign addr_ok = (paddr[1:0] == 2'h0) & (is_w | is_p | (paddr == ADDR_INSTR) | (paddr == ADDR_STATUS) |
                     (paddr == ADDR_FREG) | (paddr == ADDR_REPCNT));
    // writes wait while an instruction runs so software never races the writeback
    assign pready  = ~(access & pwrite & busy);
    assign pslverr = access & ~addr_ok;
    assign wr_take = access & pwrite & pready & addr_ok;
    assign prdata  = prdata_ff;
    assign return_pulse = ret_ff;

    assign file_src = (mode == MODE_FILE) | (mode == MODE_ACC);
    assign lit_src  = op inside {OP_SUBTRACT_LIT, OP_SUBTRACT_BORROW_LIT, OP_REV_SUBTRACT_LIT,
                                 OP_REV_SUBTRACT_BORROW_LIT};
    assign unary    = op inside {OP_ROT_LEFT_CARRY, OP_ROT_LEFT_PLAIN, OP_ROT_RIGHT_CARRY,
                                 OP_ROT_RIGHT_PLAIN, OP_SIGN_EXTEND, OP_SET_ALL_ONES};
    assign src_a    = (file_src & ~lit_src) ? freg_ff : (unary ? w_ff[ws] : w_ff[wb]);
    assign src_b    = lit_src ? {11'h000, lit14[4:0]} : (file_src ? w_ff[0] : w_ff[ws]);
    assign amt      = (op == OP_SHIFT_LEFT_LIT) ? lit14[4:0] : w_ff[ws][4:0];

    rsd_alu u_alu
    (
        .op      (op),
        .a       (src_a),
        .b       (src_b),
        .amt     (amt),
        .cin     (flags_ff[FLG_C]),
        .lit10   (lit14[9:0]),
        .prog_hi (prog_ff[w_ff[ws][2:0]][23:16]),
        .res     (alu_res),
        .flg     (alu_flg),
        .upd     (alu_upd),
        .wr      (alu_wr)
    );

    always_comb
    begin
        if (op == OP_RETURN_WITH_LITERAL)
            extra = fast ? (CYC_RET_FAST - 2'h1) : (CYC_RET_SLOW - 2'h1);
        else if (op == OP_TABLE_READ_HIGH)
            extra = CYC_TBL - 2'h1;
        else
            extra = 2'h0;
    end

    always_comb
    begin
        rd_word = 32'h00000000;
        if (paddr == ADDR_INSTR)
            rd_word = instr_ff;
        else if (paddr == ADDR_STATUS)
            rd_word = {22'h000000, armed_ff, busy, 3'h0, flags_ff};
        else if (paddr == ADDR_FREG)
            rd_word = {16'h0000, freg_ff};
        else if (paddr == ADDR_REPCNT)
            rd_word = {18'h00000, rep_ff};
        else if (is_w)
            rd_word = {16'h0000, w_ff[paddr[5:2]]};
        else if (is_p)
            rd_word = {8'h00, prog_ff[paddr[4:2]]};
        if (paddr[1:0] != 2'h0)
            rd_word = 32'h00000000;
    end

    always_comb
    begin
        nxt_w      = w_ff;
        nxt_prog   = prog_ff;
        nxt_freg   = freg_ff;
        nxt_flags  = flags_ff;
        nxt_instr  = instr_ff;
        nxt_state  = state_ff;
        nxt_wait   = wait_ff;
        nxt_rep    = rep_ff;
        nxt_armed  = armed_ff;
        nxt_ret    = 1'b0;
        nxt_prdata = (psel & ~penable & ~pwrite) ? rd_word : prdata_ff;
        fin        = 1'b0;
        if (wr_take)
        begin
            if (paddr == ADDR_INSTR)
            begin
                nxt_instr = pwdata;
                nxt_state = ST_EXEC;
            end
            else if (paddr == ADDR_STATUS)
                nxt_flags = pwdata[4:0];
            else if (paddr == ADDR_FREG)
                nxt_freg = pwdata[15:0];
            else if (is_w)
                nxt_w[paddr[5:2]] = pwdata[15:0];
            else if (is_p)
                nxt_prog[paddr[4:2]] = pwdata[23:0];
        end
        case (state_ff)
            ST_IDLE:
            begin
                nxt_wait = 2'h0;
            end
            ST_EXEC:
            begin
                if (alu_wr)
                begin
                    if ((op == OP_RETURN_WITH_LITERAL) | (op == OP_TABLE_READ_HIGH) | lit_src)
                        nxt_w[wd] = alu_res;
                    else if (mode == MODE_FILE)
                        nxt_freg = alu_res;
                    else if (mode == MODE_ACC)
                        nxt_w[0] = alu_res;
                    else
                        nxt_w[wd] = alu_res;
                end
                for (int i = 0; i < 5; i++)
                begin
                    if (alu_upd[i])
                        nxt_flags[i] = alu_flg[i];
                end
                if (op == OP_LOOP_LIT)
                begin
                    nxt_rep   = lit14;
                    nxt_armed = 1'b1;
                    nxt_state = ST_IDLE;
                end
                else if (op == OP_LOOP_REG)
                begin
                    nxt_rep   = w_ff[ws][13:0];
                    nxt_armed = 1'b1;
                    nxt_state = ST_IDLE;
                end
                else if (extra != 2'h0)
                begin
                    nxt_wait  = extra - 2'h1;
                    nxt_state = ST_WAIT;
                end
                else
                    fin = 1'b1;
            end
            ST_WAIT:
            begin
                if (wait_ff == 2'h0)
                    fin = 1'b1;
                else
                    nxt_wait = wait_ff - 2'h1;
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (fin)
        begin
            nxt_ret = (op == OP_RETURN_WITH_LITERAL);
            // an armed loop replays the same latched instruction, one pass per remaining count
            if (armed_ff & (rep_ff != 14'h0000))
            begin
                nxt_rep   = rep_ff - 14'h0001;
                nxt_state = ST_EXEC;
            end
            else
            begin
                nxt_armed = 1'b0;
                nxt_state = ST_IDLE;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NUM_W; i++)
                w_ff[i] <= WORD_RST;
            for (int i = 0; i < NUM_PROG; i++)
                prog_ff[i] <= PROG_RST;
            freg_ff   <= WORD_RST;
            flags_ff  <= FLAGS_RST;
            instr_ff  <= INSTR_RST;
            state_ff  <= ST_IDLE;
            wait_ff   <= 2'h0;
            rep_ff    <= 14'h0000;
            armed_ff  <= 1'b0;
            ret_ff    <= 1'b0;
            prdata_ff <= 32'h00000000;
        end
        else
        begin
            w_ff      <= nxt_w;
            prog_ff   <= nxt_prog;
            freg_ff   <= nxt_freg;
            flags_ff  <= nxt_flags;
            instr_ff  <= nxt_instr;
            state_ff  <= nxt_state;
            wait_ff   <= nxt_wait;
            rep_ff    <= nxt_rep;
            armed_ff  <= nxt_armed;
            ret_ff    <= nxt_ret;
            prdata_ff <= nxt_prdata;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic exec_single;
    assign exec_single = (state_ff == ST_EXEC) & ~armed_ff;

    chk_rotl_carry: assert property ((state_ff == ST_EXEC) && (op == OP_ROT_LEFT_CARRY) |=>
        (flags_ff[FLG_C] == $past(src_a[15])))
        else $error("rotate left carry lost msb");
    chk_rotl_keep: assert property ((state_ff == ST_EXEC) && (op == OP_ROT_LEFT_PLAIN) |=>
        $stable(flags_ff[FLG_C]))
        else $error("rotate left plain changed carry");
    chk_rotr_carry: assert property ((state_ff == ST_EXEC) && (op == OP_ROT_RIGHT_CARRY) |=>
        (flags_ff[FLG_C] == $past(src_a[0])))
        else $error("rotate right carry lost bit0");
    chk_rotr_neg: assert property ((state_ff == ST_EXEC) && (op == OP_ROT_RIGHT_PLAIN) |=>
        (flags_ff[FLG_N] == $past(src_a[0])) && $stable(flags_ff[FLG_C]))
        else $error("rotate right plain flags wrong");
    chk_sub_borrow: assert property ((state_ff == ST_EXEC) && (op == OP_SUBTRACT) |=>
        (flags_ff[FLG_C] == ($past(src_a) >= $past(src_b))))
        else $error("subtract carry not equal to no-borrow");
    chk_return_len: assert property (exec_single && (op == OP_RETURN_WITH_LITERAL) && !fast |->
        busy [*3] ##1 (!busy && return_pulse))
        else $error("slow return not three cycles");
    chk_tbl_len: assert property (exec_single && (op == OP_TABLE_READ_HIGH) |->
        busy [*2] ##1 !busy)
        else $error("table read not two cycles");
    chk_loop_load: assert property ((state_ff == ST_EXEC) && (op == OP_LOOP_LIT) |=>
        (rep_ff == $past(lit14)) && armed_ff && !busy)
        else $error("literal loop count not loaded");
    chk_loop_flags: assert property ((state_ff == ST_EXEC) && (op == OP_LOOP_REG) |=>
        $stable(flags_ff) && (rep_ff == $past(w_ff[ws][13:0])))
        else $error("register loop wrong count or flags");
    chk_shift_one: assert property (exec_single && (op inside {OP_SHIFT_LEFT_REG, OP_SHIFT_LEFT_LIT}) |=>
        !busy && $stable(flags_ff[FLG_C]))
        else $error("shift not single cycle or touched carry");

    cov_repeat: cover property (armed_ff && (state_ff == ST_EXEC) ##1 (state_ff == ST_EXEC));
    cov_return: cover property (return_pulse);
    cov_borrow: cover property ((state_ff == ST_EXEC) && (op == OP_SUBTRACT_BORROW) && !flags_ff[FLG_C]);
endmodule

// ---- cpu_rotate_shift_subtract_datapath_tb.sv ----
`timescale 1ns/1ns
module cpu_rotate_shift_subtract_datapath_tb
    import rsd_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        return_pulse;
    int          n_fail;
    int          tests_run;
    int          n_pulse;
    int          cyc;
    int          nw;
    logic [31:0] rd;
    logic        er;

    rsd_datapath rsd_datapath_inst (
        .pclk         (pclk),
        .presetn      (presetn),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .return_pulse (return_pulse)
    );

    initial pclk = 1'b0;
    always #5 pclk = ~pclk;

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // run needs about 650 cycles; the ceiling leaves ample margin
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (return_pulse === 1'b1)
            n_pulse = n_pulse + 1;
        if (cyc == 20000)
        begin
            n_fail = n_fail + 1;
            conclude();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error: %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // request stands until the rising edge that sees pready high; data and error are taken at that edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        nw = 0;
        do
        begin
            @(posedge pclk);
            nw++;
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        check(nm, rd, exp);
    endtask

    function automatic logic [11:0] wa(input logic [3:0] n);
        return ADDR_WORK_BASE + {6'h00, n, 2'b00};
    endfunction

    function automatic logic [31:0] ins(input rsd_op_e op, input logic [1:0] m, input logic [3:0] d,
                                        input logic [3:0] b, input logic [3:0] s, input logic [13:0] l,
                                        input logic f);
        return {l, 18'h00000} | {12'h000, s, b, d, f, m, op};
    endfunction

    // reads are never stalled, so polling the busy bit cannot hang the bus
    task automatic idle();
        do
        begin
            apb(1'b0, ADDR_STATUS, 32'h00000000);
        end
        while (rd[8] !== 1'b0);
    endtask

    // unary ops read W3, binary ops W1 with W3 (reverse forms W3 minus W1), literal ops W1 and lit5; result in W2
    task automatic alu(input rsd_op_e op, input logic [15:0] x1, input logic [15:0] x3, input logic [4:0] fi,
                       input logic [13:0] l, input logic [15:0] xr, input logic [4:0] fe);
        wr(wa(4'h1), {16'h0000, x1});
        wr(wa(4'h3), {16'h0000, x3});
        wr(ADDR_STATUS, {27'h0000000, fi});
        wr(ADDR_INSTR, ins(op, 2'h0, 4'h2, 4'h1, 4'h3, l, 1'b0));
        idle();
        rdchk({op.name(), " result"}, wa(4'h2), {16'h0000, xr});
        rdchk({op.name(), " flags"}, ADDR_STATUS, {27'h0000000, fe});
    endtask

    task automatic t_reset();
        rdchk("status after reset", ADDR_STATUS, 32'h00000000);
        rdchk("w5 after reset", wa(4'h5), 32'h00000000);
        apb(1'b0, 12'h010, 32'h00000000);
        check("unmapped error", {31'h00000000, er}, 32'h00000001);
        check("unmapped data", rd, 32'h00000000);
        apb(1'b0, 12'h042, 32'h00000000);
        check("misaligned error", {31'h00000000, er}, 32'h00000001);
    endtask

    task automatic t_alu();
        alu(OP_ROT_LEFT_CARRY, 16'h0000, 16'h8001, 5'h0A, 14'h0000, 16'h0002, 5'h0B);
        alu(OP_ROT_LEFT_PLAIN, 16'h0000, 16'h8001, 5'h05, 14'h0000, 16'h0003, 5'h01);
        alu(OP_ROT_RIGHT_CARRY, 16'h0000, 16'h0003, 5'h04, 14'h0000, 16'h0001, 5'h01);
        alu(OP_ROT_RIGHT_CARRY, 16'h0000, 16'h0002, 5'h01, 14'h0000, 16'h8001, 5'h04);
        alu(OP_ROT_RIGHT_PLAIN, 16'h0000, 16'h0001, 5'h10, 14'h0000, 16'h8000, 5'h04);
        alu(OP_SIGN_EXTEND, 16'h0000, 16'h1280, 5'h00, 14'h0000, 16'hFF80, 5'h04);
        alu(OP_SIGN_EXTEND, 16'h0000, 16'hAB7F, 5'h04, 14'h0000, 16'h007F, 5'h01);
        alu(OP_SET_ALL_ONES, 16'h0000, 16'h1234, 5'h1F, 14'h0000, 16'hFFFF, 5'h1F);
        alu(OP_SHIFT_LEFT_REG, 16'h0003, 16'h0004, 5'h1B, 14'h0000, 16'h0030, 5'h0B);
        alu(OP_SHIFT_LEFT_REG, 16'h0001, 16'h0010, 5'h00, 14'h0000, 16'h0000, 5'h10);
        alu(OP_SHIFT_LEFT_LIT, 16'h0001, 16'h0000, 5'h00, 14'h000F, 16'h8000, 5'h04);
        alu(OP_SUBTRACT, 16'h0005, 16'h0006, 5'h01, 14'h0000, 16'hFFFF, 5'h04);
        alu(OP_SUBTRACT_BORROW, 16'h8000, 16'h0001, 5'h00, 14'h0000, 16'h7FFE, 5'h09);
        alu(OP_SUBTRACT_BORROW, 16'h0003, 16'h0002, 5'h00, 14'h0000, 16'h0000, 5'h13);
        alu(OP_REV_SUBTRACT, 16'h0001, 16'h0010, 5'h00, 14'h0000, 16'h000F, 5'h01);
        alu(OP_REV_SUBTRACT_BORROW, 16'h0002, 16'h0002, 5'h01, 14'h0000, 16'h0000, 5'h13);
        alu(OP_SUBTRACT_LIT, 16'h0020, 16'h0000, 5'h00, 14'h0001, 16'h001F, 5'h01);
        alu(OP_SUBTRACT_BORROW_LIT, 16'h0010, 16'h0000, 5'h01, 14'h001F, 16'hFFF1, 5'h04);
        alu(OP_REV_SUBTRACT_LIT, 16'h000F, 16'h0000, 5'h00, 14'h001F, 16'h0010, 5'h03);
        alu(OP_REV_SUBTRACT_BORROW_LIT, 16'h7FFF, 16'h0000, 5'h00, 14'h0000, 16'h8000, 5'h04);
    endtask

    task automatic t_modes();
        wr(ADDR_FREG, 32'h00000009);
        wr(wa(4'h0), 32'h00000003);
        wr(ADDR_STATUS, 32'h00000000);
        wr(ADDR_INSTR, ins(OP_SUBTRACT, MODE_FILE, 4'h0, 4'h0, 4'h0, 14'h0000, 1'b0));
        idle();
        rdchk("file subtract", ADDR_FREG, 32'h00000006);
        rdchk("file subtract flags", ADDR_STATUS, 32'h00000003);
        wr(ADDR_INSTR, ins(OP_SET_ALL_ONES, MODE_ACC, 4'h0, 4'h0, 4'h0, 14'h0000, 1'b0));
        idle();
        rdchk("ones to accumulator", wa(4'h0), 32'h0000FFFF);
        rdchk("file kept", ADDR_FREG, 32'h00000006);
        rdchk("ones flags", ADDR_STATUS, 32'h00000003);
        wr(ADDR_INSTR, ins(OP_SET_ALL_ONES, MODE_FILE, 4'h0, 4'h0, 4'h0, 14'h0000, 1'b0));
        idle();
        rdchk("ones to file", ADDR_FREG, 32'h0000FFFF);
    endtask

    // k counts falling edges after the edge that takes the instruction write
    task automatic t_ret(input logic f, input int n);
        int k;
        wr(wa(4'h2), 32'h00000000);
        wr(ADDR_STATUS, 32'h0000001F);
        wr(ADDR_INSTR, ins(OP_RETURN_WITH_LITERAL, 2'h0, 4'h2, 4'h0, 4'h0, 14'h02A5, f));
        k = 0;
        do
        begin
            @(negedge pclk);
            k++;
        end
        while (return_pulse !== 1'b1 && k < 20);
        check("return cycles", k, n);
        @(negedge pclk);
        check("return pulse width", {31'h00000000, return_pulse}, 32'h00000000);
        idle();
        rdchk("return value", wa(4'h2), 32'h000002A5);
        rdchk("return flags", ADDR_STATUS, 32'h0000001F);
    endtask

    task automatic t_table();
        wr(ADDR_PROG_BASE + 12'h008, 32'h00ABCDEF);
        wr(wa(4'h3), 32'h00000002);
        wr(wa(4'h2), 32'h00001234);
        wr(ADDR_STATUS, 32'h0000001F);
        wr(ADDR_INSTR, ins(OP_TABLE_READ_HIGH, 2'h0, 4'h2, 4'h0, 4'h3, 14'h0000, 1'b0));
        idle();
        rdchk("table high", wa(4'h2), 32'h000000AB);
        rdchk("table flags", ADDR_STATUS, 32'h0000001F);
    endtask

    task automatic t_loop_lit();
        wr(ADDR_STATUS, 32'h0000001F);
        wr(ADDR_INSTR, ins(OP_LOOP_LIT, 2'h0, 4'h0, 4'h0, 4'h0, 14'h0004, 1'b0));
        idle();
        rdchk("loop armed", ADDR_STATUS, 32'h0000021F);
        n_pulse = 0;
        wr(ADDR_INSTR, ins(OP_RETURN_WITH_LITERAL, 2'h0, 4'h2, 4'h0, 4'h0, 14'h0011, 1'b1));
        idle();
        repeat (2) @(posedge pclk);
        check("repeat passes", n_pulse, 5);
        rdchk("loop disarmed", ADDR_STATUS, 32'h0000001F);
    endtask

    task automatic t_loop_reg();
        wr(wa(4'h3), 32'h00000002);
        wr(wa(4'h2), 32'h00000001);
        wr(ADDR_STATUS, 32'h0000000B);
        wr(ADDR_INSTR, ins(OP_LOOP_REG, 2'h0, 4'h0, 4'h0, 4'h3, 14'h0000, 1'b0));
        idle();
        rdchk("loop reg armed", ADDR_STATUS, 32'h0000020B);
        wr(ADDR_INSTR, ins(OP_ROT_LEFT_PLAIN, 2'h0, 4'h2, 4'h0, 4'h2, 14'h0000, 1'b0));
        wr(wa(4'h5), 32'h00005A5A);
        check("write stalled while busy", {31'h00000000, (nw > 1)}, 32'h00000001);
        idle();
        rdchk("three rotations", wa(4'h2), 32'h00000008);
        rdchk("stalled write landed", wa(4'h5), 32'h00005A5A);
        rdchk("loop reg flags", ADDR_STATUS, 32'h0000000B);
    endtask

    initial
    begin
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h00000000;
        presetn   = 1'b0;
        n_fail    = 0;
        tests_run = 0;
        n_pulse   = 0;
        cyc       = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_alu();
        t_modes();
        t_ret(1'b0, 4);
        t_ret(1'b1, 3);
        t_table();
        t_loop_lit();
        t_loop_reg();
        conclude();
    end
endmodule
